// *** verilog/enc_image_pkg.sv ***
package enc_image_pkg;
    // ==========================================================
    // clock and timing
    // ==========================================================
    localparam int CLK_PERIOD_NS = 8; // 125 MHz system clock
    localparam int US_NS = 1000; // one microsecond in ns
    localparam int US_CYCLES = US_NS / CLK_PERIOD_NS; // clocks per microsecond
    localparam int MS_US = 1000; // microseconds per millisecond
    localparam logic [63:0] US_PER_S = 64'h00000000000f4240; // 1e6, hz from us window
    localparam logic [15:0] FREQ_WINDOW_DEF_US = 16'h2710; // 10 ms window
    localparam logic [15:0] PERIOD_FINE_NS = 16'h0064; // 100 ns period unit
    localparam logic [15:0] PERIOD_COARSE_NS = 16'h01f4; // 500 ns period unit
    localparam logic [9:0] NS_STEP = 10'h008; // ns added per clock
    localparam int DIV_STEPS = 64; // serial divider iterations
    // ==========================================================
    // read port subindices
    // ==========================================================
    localparam logic [7:0] SUB_MAX = 8'h00;
    localparam logic [7:0] SUB_ZERO_VALID = 8'h01;
    localparam logic [7:0] SUB_EXT_VALID = 8'h02;
    localparam logic [7:0] SUB_PRESET_DONE = 8'h03;
    localparam logic [7:0] SUB_ALARM = 8'h06;
    localparam logic [7:0] SUB_WIRE_BREAK = 8'h07;
    localparam logic [7:0] SUB_PHASE_ONE = 8'h09;
    localparam logic [7:0] SUB_PHASE_TWO = 8'h0a;
    localparam logic [7:0] SUB_ZERO_LEVEL = 8'h0b;
    localparam logic [7:0] SUB_GATE = 8'h0c;
    localparam logic [7:0] SUB_EXT_LEVEL = 8'h0d;
    localparam logic [7:0] SUB_SYNC_MISS = 8'h0e;
    localparam logic [7:0] SUB_IMG_INVALID = 8'h0f;
    localparam logic [7:0] SUB_IMG_TOGGLE = 8'h10;
    localparam logic [7:0] SUB_COUNT = 8'h11;
    localparam logic [7:0] SUB_CAPTURED = 8'h12;
    localparam logic [7:0] SUB_RATE = 8'h13;
    localparam logic [7:0] SUB_INTERVAL = 8'h14;
    localparam logic [7:0] SUB_TIMESTAMP = 8'h16;
    localparam logic [7:0] MAX_SUB_VAL = 8'h16; // reset value of subindex 0
    // ==========================================================
    // carriers
    // ==========================================================
    localparam int PIN_W = 9; // width of the pin group
    typedef struct packed {
        logic wbSenseC; // line fault sense, zero-mark pair
        logic wbSenseB; // line fault sense, track two
        logic wbSenseA; // line fault sense, track one
        logic extCapture; // external capture input
        logic gateIn; // gate input
        logic zeroMark; // zero-mark input
        logic phaseTwo; // quadrature track two
        logic phaseOne; // quadrature track one
        logic alarmIn; // alarm status input
    } encPins_t;
    typedef struct packed {
        logic zeroEnable; // zero-mark capture enable
        logic extRiseEnable; // external capture on rising edge
        logic extFallEnable; // external capture on falling edge
        logic presetReq; // set-counter request level
        logic [31:0] presetValue; // value loaded by a preset
        logic distributed_clock_mode; // sync error reporting active
        logic [2:0] wbEnable; // fault sense enables c,b,a
        logic [15:0] windowUs; // frequency window, 0 = default
        logic [15:0] waitMs; // max wait for closing edge
        logic [15:0] freqScale; // frequency scaling
        logic [15:0] periodScale; // period output unit ns
        logic [15:0] periodRes; // period internal unit ns
    } encConfig_t;
    typedef enum logic [2:0] {
        FS_WINDOW = 3'b001,
        FS_WAIT = 3'b010,
        FS_DIV = 3'b100
    } freqState_t;
endpackage

// *** verilog/pin_sync2.sv ***
// two-stage synchroniser for asynchronous pins
module pin_sync2 #(
    parameter int WIDTH = 1 // number of pins
) (
    input wire logic clk_sys, // system clock
    input wire logic rst_b, // async reset, active low
    input wire logic [WIDTH-1:0] din, // raw pin levels
    output logic [WIDTH-1:0] dout // synchronised levels
);
    logic [WIDTH-1:0] meta_q; // first stage, read only by second stage

    // ==========================================================
    // sampling stages
    // ==========================================================
    // first stage feeds nothing but the second
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            meta_q <= '0;
            dout <= '0;
        end else begin
            meta_q <= din;
            dout <= meta_q;
        end
    end
endmodule // pin_sync2

// *** verilog/encoder_input_status_image.sv ***
// Overview of operation
// - zero-mark capture sets valid, holds count
// - external capture sets valid; cleared and re-armed only once both enables drop and one is set again
// - preset applied sets preset-done flag
// - alarm input level readable as status
// - open-circuit flag from enabled fault senses
// - live track, zero, gate, capture levels
// - sync miss only in distributed clock mode
// - image invalid bit: 0 valid, 1 invalid
// - toggle bit inverts on each image update
// - unsigned 32-bit scaled frequency value
// - unsigned 32-bit scaled period value
// - 64-bit timestamp of last count change
// - pulses over min window divided by time
// - period in 100 ns or 500 ns units
module encoder_input_status_image import enc_image_pkg::*; (
    input wire logic clk_sys, // system clock
    input wire logic rst_b, // async reset, active low
    input wire encPins_t pinsRaw, // asynchronous encoder pins
    input wire encConfig_t cfg, // control and configuration levels
    input wire logic syncPulse, // cycle trigger strobe
    input wire logic newData, // new process data strobe
    input wire logic imageUpdate, // transmit_process_image update strobe
    input wire logic rdReq, // read request strobe
    input wire logic [7:0] rdSub, // subindex to read
    output logic [63:0] rdData_q, // read data
    output logic rdAck_q, // read answered
    output logic rdErr_q // unmapped subindex
);
    // ==========================================================
    // pins and edges
    // ==========================================================
    encPins_t pins; // synchronised pins
    encPins_t pinsPrev_q; // previous synchronised pins
    logic cfgPrevZero_q, cfgPrevExt_q, cfgPrevPreset_q; // enable history
    pin_sync2 #(.WIDTH(PIN_W)) uSync (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .din(pinsRaw),
        .dout(pins)
    );
    logic aRise, aChg, bChg, zeroRise, extRise, extFall, presetEdge, zeroEnRise, extEnRise, extEn;
    assign aRise = pins.phaseOne & ~pinsPrev_q.phaseOne;
    assign aChg = pins.phaseOne ^ pinsPrev_q.phaseOne;
    assign bChg = pins.phaseTwo ^ pinsPrev_q.phaseTwo;
    assign zeroRise = pins.zeroMark & ~pinsPrev_q.zeroMark;
    assign extRise = pins.extCapture & ~pinsPrev_q.extCapture;
    assign extFall = ~pins.extCapture & pinsPrev_q.extCapture;
    assign presetEdge = cfg.presetReq & ~cfgPrevPreset_q;
    assign zeroEnRise = cfg.zeroEnable & ~cfgPrevZero_q;
    assign extEn = cfg.extRiseEnable | cfg.extFallEnable;
    assign extEnRise = extEn & ~cfgPrevExt_q;
    // history only, no next-state logic needed
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            pinsPrev_q <= '0;
            cfgPrevZero_q <= 1'b0;
            cfgPrevExt_q <= 1'b0;
            cfgPrevPreset_q <= 1'b0;
        end else begin
            pinsPrev_q <= pins;
            cfgPrevZero_q <= cfg.zeroEnable;
            cfgPrevExt_q <= extEn;
            cfgPrevPreset_q <= cfg.presetReq;
        end
    end
    // ==========================================================
    // count, captures, preset, timestamp
    // ==========================================================
    logic [31:0] count_q, count_d; // position count
    logic [31:0] captured_q, captured_d; // captured count
    logic zeroArm_q, zeroArm_d, zeroValid_q, zeroValid_d; // zero-mark capture
    logic extArm_q, extArm_d, extValid_q, extValid_d; // external capture
    logic presetDone_q, presetDone_d; // preset applied
    logic [63:0] timeNs_q, stamp_q, stamp_d; // free time and change stamp
    logic zeroHit, extHit; // capture events this cycle
    always_comb begin
        zeroHit = zeroArm_q & cfg.zeroEnable & zeroRise;
        extHit = extArm_q & ((cfg.extRiseEnable & extRise) | (cfg.extFallEnable & extFall));
        count_d = count_q;
        if (presetEdge) begin
            count_d = cfg.presetValue;
        end else if (aChg ^ bChg) begin
            // both tracks moving at once is a lost step, ignored
            if (~(pinsPrev_q.phaseOne ^ pins.phaseTwo)) begin
                count_d = count_q + 32'h00000001;
            end else begin
                count_d = count_q - 32'h00000001;
            end
        end
        // zero capture wins the value when both fire together
        captured_d = zeroHit ? count_q : (extHit ? count_q : captured_q);
        // cancelling the enable disarms and drops the flag; rising re-arms
        zeroArm_d = cfg.zeroEnable & (zeroEnRise | (zeroArm_q & ~zeroHit));
        zeroValid_d = cfg.zeroEnable & (zeroValid_q | zeroHit);
        extArm_d = extEn & (extEnRise | (extArm_q & ~extHit));
        extValid_d = extEn & (extValid_q | extHit);
        presetDone_d = cfg.presetReq & (presetDone_q | presetEdge);
        stamp_d = (count_d != count_q) ? timeNs_q : stamp_q;
    end
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            count_q <= '0;
            captured_q <= '0;
            zeroArm_q <= 1'b0;
            zeroValid_q <= 1'b0;
            extArm_q <= 1'b0;
            extValid_q <= 1'b0;
            presetDone_q <= 1'b0;
            timeNs_q <= '0;
            stamp_q <= '0;
        end else begin
            count_q <= count_d;
            captured_q <= captured_d;
            zeroArm_q <= zeroArm_d;
            zeroValid_q <= zeroValid_d;
            extArm_q <= extArm_d;
            extValid_q <= extValid_d;
            presetDone_q <= presetDone_d;
            timeNs_q <= timeNs_q + 64'(NS_STEP);
            stamp_q <= stamp_d;
        end
    end
    // ==========================================================
    // status flags: wire break, sync, image
    // ==========================================================
    logic wireBreak_q, wireBreak_d, seenData_q, seenData_d; // fault, data seen
    logic syncMiss_q, syncMiss_d, imgToggle_q, imgToggle_d; // sync, toggle
    always_comb begin
        wireBreak_d = |({pins.wbSenseC, pins.wbSenseB, pins.wbSenseA} & cfg.wbEnable);
        // data arriving with the trigger still counts for the closing cycle
        seenData_d = syncPulse ? 1'b0 : (seenData_q | newData);
        syncMiss_d = syncMiss_q;
        if (!cfg.distributed_clock_mode) begin
            syncMiss_d = 1'b0;
        end else if (syncPulse) begin
            syncMiss_d = ~(seenData_q | newData);
        end
        imgToggle_d = imgToggle_q ^ imageUpdate;
    end
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            wireBreak_q <= 1'b0;
            seenData_q <= 1'b0;
            syncMiss_q <= 1'b0;
            imgToggle_q <= 1'b0;
        end else begin
            wireBreak_q <= wireBreak_d;
            seenData_q <= seenData_d;
            syncMiss_q <= syncMiss_d;
            imgToggle_q <= imgToggle_d;
        end
    end
    // ==========================================================
    // period and frequency measurement
    // ==========================================================
    logic [6:0] usCnt_q, usCnt_d; // microsecond divider
    logic usTick; // one pulse per microsecond
    logic [9:0] nsAcc_q, nsAcc_d; // ns toward next period unit
    logic [31:0] perCnt_q, perCnt_d, period_q, period_d; // period units
    logic [15:0] perUnit; // internal period unit ns
    logic [31:0] winUs_q, winUs_d, pulses_q, pulses_d, freq_q, freq_d; // freq path
    logic [31:0] winLen, waitLen; // window and wait limit in us
    logic [32:0] rem_q, rem_d, remShift; // divider remainder
    logic [63:0] quot_q, quot_d; // divider numerator and quotient
    logic [6:0] divCnt_q, divCnt_d; // divider step count
    freqState_t fst_q, fst_d; // frequency sequencer
    assign usTick = (usCnt_q == 7'(US_CYCLES - 1));
    // a coarse internal unit forces coarse counting, scaled up on output
    assign perUnit = (cfg.periodRes == PERIOD_COARSE_NS || cfg.periodScale == PERIOD_COARSE_NS)
        ? PERIOD_COARSE_NS : PERIOD_FINE_NS;
    assign winLen = {16'h0000, (cfg.windowUs == 16'h0000) ? FREQ_WINDOW_DEF_US : cfg.windowUs};
    assign waitLen = winLen + 32'(cfg.waitMs) * 32'(MS_US);
    assign remShift = {rem_q[31:0], quot_q[63]};
    always_comb begin
        usCnt_d = usTick ? 7'h00 : usCnt_q + 7'h01;
        nsAcc_d = nsAcc_q + NS_STEP;
        perCnt_d = perCnt_q;
        period_d = period_q;
        if (nsAcc_d >= perUnit[9:0]) begin
            nsAcc_d = nsAcc_d - perUnit[9:0];
            perCnt_d = (perCnt_q == 32'hffffffff) ? perCnt_q : perCnt_q + 32'h00000001;
        end
        if (aRise) begin
            // the edge cycle is the first 8 ns of the new period
            nsAcc_d = NS_STEP;
            perCnt_d = '0;
            period_d = (perUnit != cfg.periodScale) ? {perCnt_q[29:0], 2'b00} + perCnt_q
                : perCnt_q;
        end
        fst_d = fst_q;
        winUs_d = (usTick && fst_q != FS_DIV) ? winUs_q + 32'h00000001 : winUs_q;
        pulses_d = aRise ? pulses_q + 32'h00000001 : pulses_q;
        rem_d = rem_q;
        quot_d = quot_q;
        divCnt_d = divCnt_q;
        freq_d = freq_q;
        case (fst_q)
            FS_WINDOW: begin
                if (winUs_q >= winLen) begin
                    fst_d = FS_WAIT; // minimum window elapsed
                end
            end
            FS_WAIT: begin
                if (aRise || winUs_q >= waitLen) begin
                    // numerator in scaled hz-microseconds
                    quot_d = 64'(pulses_d) * 64'(cfg.freqScale) * US_PER_S;
                    rem_d = '0;
                    divCnt_d = '0;
                    fst_d = FS_DIV;
                end
            end
            FS_DIV: begin
                // pulses and window frozen while dividing, 64 clocks lost
                pulses_d = pulses_q;
                if (remShift >= {1'b0, winUs_q}) begin
                    rem_d = remShift - {1'b0, winUs_q};
                    quot_d = {quot_q[62:0], 1'b1};
                end else begin
                    rem_d = remShift;
                    quot_d = {quot_q[62:0], 1'b0};
                end
                divCnt_d = divCnt_q + 7'h01;
                if (divCnt_q == 7'(DIV_STEPS - 1)) begin
                    // divide by the actual window, saturating
                    freq_d = (quot_d[63:32] != '0) ? 32'hffffffff : quot_d[31:0];
                    winUs_d = '0;
                    pulses_d = '0;
                    fst_d = FS_WINDOW;
                end
            end
            default: fst_d = FS_WINDOW;
        endcase
    end
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            usCnt_q <= '0;
            nsAcc_q <= '0;
            perCnt_q <= '0;
            period_q <= '0;
            fst_q <= FS_WINDOW;
            winUs_q <= '0;
            pulses_q <= '0;
            rem_q <= '0;
            quot_q <= '0;
            divCnt_q <= '0;
            freq_q <= '0;
        end else begin
            usCnt_q <= usCnt_d;
            nsAcc_q <= nsAcc_d;
            perCnt_q <= perCnt_d;
            period_q <= period_d;
            fst_q <= fst_d;
            winUs_q <= winUs_d;
            pulses_q <= pulses_d;
            rem_q <= rem_d;
            quot_q <= quot_d;
            divCnt_q <= divCnt_d;
            freq_q <= freq_d;
        end
    end
    // ==========================================================
    // read port
    // ==========================================================
    logic [63:0] rdData_d; // value for the subindex
    logic rdAck_d, rdErr_d; // answer and fault
    always_comb begin
        rdData_d = rdData_q;
        rdErr_d = 1'b0;
        rdAck_d = rdReq;
        if (rdReq) begin
            case (rdSub)
                SUB_MAX: rdData_d = {56'h0, MAX_SUB_VAL};
                SUB_ZERO_VALID: rdData_d = {63'h0, zeroValid_q};
                SUB_EXT_VALID: rdData_d = {63'h0, extValid_q};
                SUB_PRESET_DONE: rdData_d = {63'h0, presetDone_q};
                SUB_ALARM: rdData_d = {63'h0, pins.alarmIn};
                SUB_WIRE_BREAK: rdData_d = {63'h0, wireBreak_q};
                SUB_PHASE_ONE: rdData_d = {63'h0, pins.phaseOne};
                SUB_PHASE_TWO: rdData_d = {63'h0, pins.phaseTwo};
                SUB_ZERO_LEVEL: rdData_d = {63'h0, pins.zeroMark};
                SUB_GATE: rdData_d = {63'h0, pins.gateIn};
                SUB_EXT_LEVEL: rdData_d = {63'h0, pins.extCapture};
                SUB_SYNC_MISS: rdData_d = {63'h0, syncMiss_q};
                // the image is invalid while the line is broken
                SUB_IMG_INVALID: rdData_d = {63'h0, wireBreak_q};
                SUB_IMG_TOGGLE: rdData_d = {63'h0, imgToggle_q};
                SUB_COUNT: rdData_d = {32'h0, count_q};
                SUB_CAPTURED: rdData_d = {32'h0, captured_q};
                SUB_RATE: rdData_d = {32'h0, freq_q};
                SUB_INTERVAL: rdData_d = {32'h0, period_q};
                SUB_TIMESTAMP: rdData_d = stamp_q;
                default: begin
                    rdData_d = '0; // unmapped reads zero
                    rdErr_d = 1'b1;
                end
            endcase
        end
    end
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rdData_q <= '0;
            rdAck_q <= 1'b0;
            rdErr_q <= 1'b0;
        end else begin
            rdData_q <= rdData_d;
            rdAck_q <= rdAck_d;
            rdErr_q <= rdErr_d;
        end
    end
    // ==========================================================
    // assertions
    // ==========================================================
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    zero_capture_a: assert property ($rose(zeroValid_q) |-> captured_q == $past(count_q))
        else $error("zero capture value wrong");
    zero_rearm_a: assert property (zeroValid_q && !cfg.zeroEnable |=> !zeroValid_q && !zeroArm_q)
        else $error("zero capture not dropped");
    ext_capture_a: assert property (extHit |=> extValid_q && captured_q == $past(count_q))
        else $error("external capture wrong");
    preset_done_a: assert property (presetEdge |=> presetDone_q && count_q == $past(cfg.presetValue))
        else $error("preset not applied");
    alarm_read_a: assert property (rdReq && rdSub == SUB_ALARM |=> rdAck_q && rdData_q == {63'h0, $past(pins.alarmIn)})
        else $error("alarm level misread");
    sync_miss_a: assert property (syncPulse && cfg.distributed_clock_mode && !seenData_q && !newData |=> syncMiss_q)
        else $error("sync miss not flagged");
    sync_mode_a: assert property (!cfg.distributed_clock_mode |=> !syncMiss_q)
        else $error("sync miss outside mode");
    image_toggle_a: assert property (imageUpdate |=> imgToggle_q != $past(imgToggle_q))
        else $error("toggle not inverted");
    count_step_a: assert property (!presetEdge && (aChg ^ bChg) |=> count_q != $past(count_q))
        else $error("count did not step");
    stamp_time_a: assert property (count_q != $past(count_q) |-> stamp_q == $past(timeNs_q))
        else $error("timestamp not taken");
    freq_window_a: assert property ($rose(fst_q == FS_WAIT) |-> winUs_q >= winLen)
        else $error("window closed early");
    zero_hit_c: cover property (zeroHit);
    freq_done_c: cover property (fst_q == FS_DIV ##1 fst_q == FS_WINDOW);
    sync_miss_c: cover property ($rose(syncMiss_q));
endmodule // encoder_input_status_image

// *** testbench/quad_encoder_model.sv ***
// two-track encoder: one track edge per requested step
module quad_encoder_model (
    input wire logic clk_sys, // system clock
    input wire logic rst_b, // reset, active low
    input wire logic stepUp, // one forward edge
    input wire logic stepDown, // one backward edge
    output logic phaseOne, // track one
    output logic phaseTwo // track two
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] pos_q; // place in the four-state cycle
    // forward order 00,10,11,01: track one leads
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) pos_q <= 2'h0;
        else if (stepUp) pos_q <= pos_q + 2'h1;
        else if (stepDown) pos_q <= pos_q - 2'h1;
    end
    // gray code: never both tracks at once
    assign phaseOne = pos_q[1] ^ pos_q[0];
    assign phaseTwo = pos_q[1];
endmodule // quad_encoder_model

// *** testbench/test_encoder_input_status_image.sv ***
module test_encoder_input_status_image import enc_image_pkg::*; ();
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // wiring
    // ==========================================================
    logic clk_sys = 1'b0; // system clock
    logic rst_b = 1'b0; // reset, active low
    encPins_t pins = '0; // bench-driven pins
    encPins_t pinsRaw; // pins seen by the block
    encConfig_t cfg = '0; // control levels
    logic [2:0] strb = 3'h0; // sync, new data, update
    logic rdReq = 1'b0, stepUp = 1'b0, stepDown = 1'b0; // requests
    logic [7:0] rdSub = 8'h00; // read subindex
    logic phaseOne, phaseTwo, rdAck_q, rdErr_q; // model and dut outputs
    logic [63:0] rdData_q, t1, t2; // read data, stamps
    logic [7:0] subs [5] = '{SUB_ZERO_VALID, SUB_PRESET_DONE, SUB_WIRE_BREAK,
        SUB_SYNC_MISS, SUB_COUNT}; // zero after reset
    int n_fail = 0, comparisons = 0, cycles = 0; // counters
    initial forever #4 clk_sys = ~clk_sys;
    // tracks come from the model, the rest from the bench
    always_comb begin
        pinsRaw = pins;
        pinsRaw.phaseOne = phaseOne;
        pinsRaw.phaseTwo = phaseTwo;
    end
    quad_encoder_model enc (.clk_sys(clk_sys), .rst_b(rst_b), .stepUp(stepUp),
        .stepDown(stepDown), .phaseOne(phaseOne), .phaseTwo(phaseTwo));
    encoder_input_status_image dut (.clk_sys(clk_sys), .rst_b(rst_b), .pinsRaw(pinsRaw),
        .cfg(cfg), .syncPulse(strb[2]), .newData(strb[1]), .imageUpdate(strb[0]),
        .rdReq(rdReq), .rdSub(rdSub), .rdData_q(rdData_q), .rdAck_q(rdAck_q),
        .rdErr_q(rdErr_q));
    // ==========================================================
    // tasks
    // ==========================================================
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    // answer registered at the taking edge, sampled at the next one
    task automatic fetch(input logic [7:0] s, output logic [63:0] d);
        @(posedge clk_sys);
        rdReq <= 1'b1;
        rdSub <= s;
        @(posedge clk_sys);
        rdReq <= 1'b0;
        @(posedge clk_sys);
        check({63'h0, rdAck_q}, 64'h1);
        d = rdData_q;
    endtask
    task automatic rd(input logic [7:0] s, input logic [63:0] exp);
        logic [63:0] d;
        fetch(s, d);
        check(d, exp);
    endtask
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic pulse(input logic [2:0] m);
        @(posedge clk_sys);
        strb <= m;
        @(posedge clk_sys);
        strb <= 3'h0;
    endtask
    // settle time covers synchroniser plus count register
    task automatic step(input logic up, input int n);
        repeat (n) begin
            @(posedge clk_sys);
            stepUp <= up;
            stepDown <= !up;
            @(posedge clk_sys);
            stepUp <= 1'b0;
            stepDown <= 1'b0;
        end
        wait_clk(5);
    endtask
    task automatic complete_run();
        $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // hang guard, several times the run length
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            n_fail++;
            complete_run();
        end
    end
    // ==========================================================
    // tests
    // ==========================================================
    initial begin
        wait_clk(4);
        rst_b <= 1'b1;
        // short frequency window so one measurement ends in the run
        cfg.windowUs <= 16'h0008;
        cfg.freqScale <= 16'h0001;
        cfg.periodScale <= PERIOD_FINE_NS;
        rd(SUB_MAX, {56'h0, MAX_SUB_VAL});
        foreach (subs[i]) rd(subs[i], 64'h0);
        fetch(8'h05, t1);
        check({63'h0, rdErr_q}, 64'h1);
        check(t1, 64'h0);
        $display("test reset done");
        pins.alarmIn <= 1'b1;
        pins.gateIn <= 1'b1;
        step(1'b1, 4);
        step(1'b0, 1);
        rd(SUB_ALARM, 64'h1);
        rd(SUB_GATE, 64'h1);
        rd(SUB_PHASE_TWO, 64'h1);
        rd(SUB_COUNT, 64'h3);
        fetch(SUB_TIMESTAMP, t1);
        fetch(SUB_TIMESTAMP, t2);
        check(t2, t1);
        check({63'h0, t1 != 64'h0}, 64'h1);
        $display("test count done");
        cfg.zeroEnable <= 1'b1;
        cfg.extRiseEnable <= 1'b1;
        wait_clk(2);
        pins.zeroMark <= 1'b1;
        pins.extCapture <= 1'b1;
        wait_clk(5);
        rd(SUB_ZERO_VALID, 64'h1);
        rd(SUB_EXT_VALID, 64'h1);
        rd(SUB_CAPTURED, 64'h3);
        rd(SUB_EXT_LEVEL, 64'h1);
        cfg.zeroEnable <= 1'b0;
        wait_clk(3);
        rd(SUB_ZERO_VALID, 64'h0);
        // re-arm, one step up, then a fresh zero mark
        cfg.zeroEnable <= 1'b1;
        pins.zeroMark <= 1'b0;
        step(1'b1, 1);
        pins.zeroMark <= 1'b1;
        wait_clk(5);
        rd(SUB_ZERO_VALID, 64'h1);
        rd(SUB_CAPTURED, 64'h4);
        $display("test capture done");
        cfg.presetValue <= 32'h12345678;
        cfg.presetReq <= 1'b1;
        cfg.wbEnable <= 3'h1;
        pins.wbSenseA <= 1'b1;
        wait_clk(4);
        rd(SUB_PRESET_DONE, 64'h1);
        rd(SUB_COUNT, 64'h12345678);
        rd(SUB_WIRE_BREAK, 64'h1);
        rd(SUB_IMG_INVALID, 64'h1);
        $display("test preset done");
        cfg.distributed_clock_mode <= 1'b1;
        pulse(3'h4);
        pulse(3'h4);
        rd(SUB_SYNC_MISS, 64'h1);
        pulse(3'h2);
        pulse(3'h4);
        rd(SUB_SYNC_MISS, 64'h0);
        pulse(3'h1);
        pulse(3'h1);
        pulse(3'h1);
        rd(SUB_IMG_TOGGLE, 64'h1);
        $display("test image done");
        // track one rises 13 clocks apart: 104 ns, one 100 ns unit
        step(1'b1, 4);
        step(1'b1, 4);
        rd(SUB_INTERVAL, 64'h1);
        rd(SUB_COUNT, 64'h12345680);
        // three rises in the first 8 us window: 3 * 1e6 / 8
        wait_clk(1000);
        rd(SUB_RATE, 64'h000000000005b8d8);
        $display("test measure done");
        complete_run();
    end
endmodule // test_encoder_input_status_image
